// *** ebpm_regs.svh ***
`ifndef EBPM_REGS_SVH
`define EBPM_REGS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define EBPM_ADDR_MODE      12'h000
`define EBPM_ADDR_SEL_DATA  12'h004
`define EBPM_ADDR_SEL_ADDR  12'h008
`define EBPM_ADDR_SEL_CTRL  12'h00c
`define EBPM_ADDR_PORT_OUT  12'h010
`define EBPM_ADDR_PORT_OE   12'h014
`define EBPM_ADDR_PORT_IN   12'h018
`define EBPM_ADDR_STATUS    12'h01c
`define EBPM_ADDR_PORT_OUT2 12'h020
`define EBPM_ADDR_PORT_OE2  12'h024
`define EBPM_ADDR_PORT_IN2  12'h028

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define EBPM_MODE_WIDE_BIT  0
`define EBPM_MODE_SINGLE_BIT 1
`define EBPM_MODE_EOP_BIT   2
`define EBPM_MODE_RST       32'h0000_0000
`define EBPM_SEL_RST        32'hffff_ffff
`define EBPM_ZERO32         32'h0000_0000

// Control pin positions within the control select word
`define EBPM_CTL_RDY  0
`define EBPM_CTL_ACK  1
`define EBPM_CTL_REQ  2
`define EBPM_CTL_RD   3
`define EBPM_CTL_WRU  4
`define EBPM_CTL_WRL  5
`define EBPM_CTL_A24  6

// Pin group positions within select, port and data words
`define EBPM_MID_LSB    16
`define EBPM_TOP_LSB    24
`define EBPM_MID_P2_LSB 8
`define EBPM_LANE_PINS  8
`define EBPM_ADDR_PINS  24
`define EBPM_CTL_PINS   6

`endif

// *** ebpm_pkg.sv ***
`default_nettype none

package ebpm_pkg;

  // Bus ownership states
  typedef enum logic [1:0] {
    EBPM_OWN      = 2'b00,
    EBPM_RELEASED = 2'b01
  } ebpm_own_e;

  // Whole register state of the block
  typedef struct packed {
    logic [31:0] mode;
    logic [31:0] selData;
    logic [31:0] selAddr;
    logic [31:0] selCtrl;
    logic [31:0] portOut;
    logic [31:0] portOe;
    logic [31:0] portOut2;
    logic [31:0] portOe2;
    logic [31:0] prdata;
    logic [31:0] padIn1;
    logic [31:0] padIn2;
    logic [31:0] padSync1;
    logic [31:0] padSync2;
    logic        reset2;
    ebpm_own_e   own;
  } ebpm_state_s;

endpackage : ebpm_pkg

`default_nettype wire

// *** ebpm_pin_mux.sv ***
// Notes on behaviour
// - Middle data lane pins become port pins in 8-bit width or single chip mode.
// - Top data lane bits 24 to 31 travel on their own eight pins while the bus is active, each pin reusable as a port when deselected.
// - Address bits 0 to 15 drive their pins, each pin falling back to port use when unneeded.
// - Address bits 16 to 23 drive their pins, each reusable as a port when unneeded.
// - The address bit 24 pin carries the DMA channel 0 end output when enabled, else address or port.
// - A low ready input stretches the current external cycle until it goes high again.
// - The release acknowledge is low while the bus is released and high while it is owned.
// - The read strobe drives its pin for reads and the pin reverts to port use when unused.
// - The upper write strobe qualifies bits 31-24 in both widths, the lower only in 16-bit mode.
// - The lower write strobe pin floats during reset; boards using 16-bit width add a pull-up.
`default_nettype none
`include "ebpm_regs.svh"

module ebpm_pin_mux
  import ebpm_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Bus controller side
  input  wire logic [31:0] busDataOut,
  input  wire logic        busDataDrive,
  output logic      [31:0] busDataIn,
  input  wire logic [24:0] busAddr,
  input  wire logic        busReadStrobe_n,
  input  wire logic        busWriteUpper_n,
  input  wire logic        busWriteLower_n,
  input  wire logic        dmaCh0TransferEnd,
  output logic             busCycleHold,
  output logic             busReleased,
  input  wire logic        busIdle,
  // data_lane_mid / port_group_two pins
  input  wire logic [7:0]  data_lane_mid_in,
  output logic      [7:0]  data_lane_mid_out,
  output logic      [7:0]  data_lane_mid_oe_n,
  // data_lane_top / port_group_three pins
  input  wire logic [7:0]  data_lane_top_in,
  output logic      [7:0]  data_lane_top_out,
  output logic      [7:0]  data_lane_top_oe_n,
  // addr_low_bits and addr_high_bits pins
  input  wire logic [23:0] addr_bits_in,
  output logic      [23:0] addr_bits_out,
  output logic      [23:0] addr_bits_oe_n,
  // addr_top_bit / dma_ch0_transfer_end_out pin
  input  wire logic        addr_top_bit_in,
  output logic             addr_top_bit_out,
  output logic             addr_top_bit_oe_n,
  // Control pins, index per control select word
  input  wire logic [5:0]  ctrl_pin_in,
  output logic      [5:0]  ctrl_pin_out,
  output logic      [5:0]  ctrl_pin_oe_n
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  ebpm_state_s st;
  ebpm_state_s next_st;

  logic        apbWrite;
  logic        apbRead;
  logic        wide;
  logic        single;
  logic [31:0] padRaw1;
  logic [31:0] padRaw2;
  logic [31:0] statusWord;
  logic        busPins;
  logic        useMid;
  logic        useTop;
  logic        useA24;
  logic        useRead;
  logic        useWrUpper;
  logic        useWrLower;
  logic        dataDrive;
  logic        busDrive;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Write data into a register on address match
  function automatic logic [31:0] regWr(input logic [31:0] cur, input logic hit, input logic [31:0] wd);
    regWr = hit ? wd : cur;
  endfunction : regWr

  // Pick pin drive: bus function or port function
  function automatic logic [1:0] pinMux(input logic useBus, input logic busVal, input logic busDrv,
                                        input logic portVal, input logic portOe);
    pinMux = useBus ? {busVal, ~busDrv} : {portVal, ~portOe};
  endfunction : pinMux

  // ----------------------------------------
  // Combinational decode
  // ----------------------------------------
  assign apbWrite = psel && penable && pwrite;
  assign apbRead  = psel && !penable && !pwrite;
  assign wide     = st.mode[`EBPM_MODE_WIDE_BIT];
  assign single   = st.mode[`EBPM_MODE_SINGLE_BIT];

  // ----------------------------------------
  // Input pad sampling
  // ----------------------------------------
  // Pins are asynchronous to the clock; both words pass two flops before use
  assign padRaw1  = {data_lane_top_in, addr_bits_in};
  assign padRaw2  = {16'h0000, data_lane_mid_in, 1'b0, addr_top_bit_in, ctrl_pin_in};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Next state: register writes, read capture, pad sync, bus ownership
  always_comb begin
    next_st          = st;
    next_st.selData  = regWr(st.selData,  apbWrite && paddr == `EBPM_ADDR_SEL_DATA,  pwdata);
    next_st.selAddr  = regWr(st.selAddr,  apbWrite && paddr == `EBPM_ADDR_SEL_ADDR,  pwdata);
    next_st.selCtrl  = regWr(st.selCtrl,  apbWrite && paddr == `EBPM_ADDR_SEL_CTRL,  pwdata);
    next_st.portOut  = regWr(st.portOut,  apbWrite && paddr == `EBPM_ADDR_PORT_OUT,  pwdata);
    next_st.portOe   = regWr(st.portOe,   apbWrite && paddr == `EBPM_ADDR_PORT_OE,   pwdata);
    next_st.portOut2 = regWr(st.portOut2, apbWrite && paddr == `EBPM_ADDR_PORT_OUT2, pwdata);
    next_st.portOe2  = regWr(st.portOe2,  apbWrite && paddr == `EBPM_ADDR_PORT_OE2,  pwdata);
    next_st.mode     = regWr(st.mode,     apbWrite && paddr == `EBPM_ADDR_MODE,      pwdata);
    // Two-stage pad synchronisers; only the second stage is read
    next_st.padSync1 = padRaw1;
    next_st.padIn1   = st.padSync1;
    next_st.padSync2 = padRaw2;
    next_st.padIn2   = st.padSync2;
    // Reset release marker; lower strobe stays floating until first clocked cycle
    next_st.reset2   = 1'b1;
    // Hand bus over only between cycles; keep it while request stays high
    case (st.own)
      EBPM_OWN: begin
        if (st.selCtrl[`EBPM_CTL_REQ] && st.padIn2[`EBPM_CTL_REQ] && busIdle) begin
          next_st.own = EBPM_RELEASED;
        end
      end
      EBPM_RELEASED: begin
        if (!(st.selCtrl[`EBPM_CTL_REQ] && st.padIn2[`EBPM_CTL_REQ])) begin
          next_st.own = EBPM_OWN;
        end
      end
      default: next_st.own = EBPM_OWN;
    endcase
    // Read data captured in the setup cycle, shown in the access cycle
    if (apbRead) begin
      case (paddr)
        `EBPM_ADDR_MODE:      next_st.prdata = st.mode;
        `EBPM_ADDR_SEL_DATA:  next_st.prdata = st.selData;
        `EBPM_ADDR_SEL_ADDR:  next_st.prdata = st.selAddr;
        `EBPM_ADDR_SEL_CTRL:  next_st.prdata = st.selCtrl;
        `EBPM_ADDR_PORT_OUT:  next_st.prdata = st.portOut;
        `EBPM_ADDR_PORT_OE:   next_st.prdata = st.portOe;
        `EBPM_ADDR_PORT_IN:   next_st.prdata = st.padIn1;
        `EBPM_ADDR_STATUS:    next_st.prdata = statusWord;
        `EBPM_ADDR_PORT_OUT2: next_st.prdata = st.portOut2;
        `EBPM_ADDR_PORT_OE2:  next_st.prdata = st.portOe2;
        `EBPM_ADDR_PORT_IN2:  next_st.prdata = st.padIn2;
        default:              next_st.prdata = `EBPM_ZERO32;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Register the whole state; asynchronous reset to constants
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st          <= '0;
      st.mode     <= `EBPM_MODE_RST;
      st.selData  <= `EBPM_SEL_RST;
      st.selAddr  <= `EBPM_SEL_RST;
      st.selCtrl  <= `EBPM_SEL_RST;
      st.own      <= EBPM_OWN;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  // Zero wait state slave; unmapped reads return zero without error
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = st.prdata;

  // ----------------------------------------
  // Pin function selection
  // ----------------------------------------
  // Single chip mode frees the data, address and strobe pins; the middle lane also needs 16-bit width
  assign busPins    = !single;
  assign useMid     = busPins && wide;
  assign useTop     = busPins;
  // Each control pin also needs its own select bit
  assign useA24     = busPins && st.selCtrl[`EBPM_CTL_A24];
  assign useRead    = busPins && st.selCtrl[`EBPM_CTL_RD];
  assign useWrUpper = busPins && st.selCtrl[`EBPM_CTL_WRU];
  assign useWrLower = busPins && wide && st.selCtrl[`EBPM_CTL_WRL];
  // The other master owns a released bus, so no data or address pin may drive
  assign dataDrive  = busDataDrive && !busReleased;
  assign busDrive   = !busReleased;

  // ----------------------------------------
  // Pin multiplexing
  // ----------------------------------------
  // Middle lane: bus only in 16-bit width outside single chip mode
  always_comb begin
    for (int i = 0; i < `EBPM_LANE_PINS; i++) begin
      {data_lane_mid_out[i], data_lane_mid_oe_n[i]} = pinMux(useMid && st.selData[`EBPM_MID_LSB + i],
                                                             busDataOut[`EBPM_MID_LSB + i], dataDrive,
                                                             st.portOut2[`EBPM_MID_P2_LSB + i],
                                                             st.portOe2[`EBPM_MID_P2_LSB + i]);
    end
  end

  // Top lane: present in every bus mode
  always_comb begin
    for (int i = 0; i < `EBPM_LANE_PINS; i++) begin
      {data_lane_top_out[i], data_lane_top_oe_n[i]} = pinMux(useTop && st.selData[`EBPM_TOP_LSB + i],
                                                             busDataOut[`EBPM_TOP_LSB + i], dataDrive,
                                                             st.portOut[`EBPM_TOP_LSB + i],
                                                             st.portOe[`EBPM_TOP_LSB + i]);
    end
  end

  // Address bits 0 to 23; outputs when used as address unless the bus is released
  always_comb begin
    for (int i = 0; i < `EBPM_ADDR_PINS; i++) begin
      {addr_bits_out[i], addr_bits_oe_n[i]} = pinMux(busPins && st.selAddr[i],
                                                     busAddr[i], busDrive,
                                                     st.portOut[i], st.portOe[i]);
    end
  end

  // Address bit 24 pin: DMA end output has priority over the address
  always_comb begin
    if (st.mode[`EBPM_MODE_EOP_BIT]) begin
      addr_top_bit_out  = dmaCh0TransferEnd;
      addr_top_bit_oe_n = 1'b0;
    end else begin
      {addr_top_bit_out, addr_top_bit_oe_n} = pinMux(useA24,
                                                     busAddr[`EBPM_ADDR_PINS], busDrive,
                                                     st.portOut2[`EBPM_CTL_A24], st.portOe2[`EBPM_CTL_A24]);
    end
  end

  // Control pins; ready and request are inputs in bus use
  always_comb begin
    // Port function first; each bus use below overrides its own pin
    for (int i = 0; i < `EBPM_CTL_PINS; i++) begin
      {ctrl_pin_out[i], ctrl_pin_oe_n[i]} = {st.portOut2[i], ~st.portOe2[i]};
    end
    // Ready and request only listen while selected
    if (st.selCtrl[`EBPM_CTL_RDY]) begin
      ctrl_pin_out[`EBPM_CTL_RDY]  = 1'b0;
      ctrl_pin_oe_n[`EBPM_CTL_RDY] = 1'b1;
    end
    if (st.selCtrl[`EBPM_CTL_REQ]) begin
      ctrl_pin_out[`EBPM_CTL_REQ]  = 1'b0;
      ctrl_pin_oe_n[`EBPM_CTL_REQ] = 1'b1;
    end
    // Acknowledge level follows ownership in every mode
    if (st.selCtrl[`EBPM_CTL_ACK]) begin
      ctrl_pin_out[`EBPM_CTL_ACK]  = st.own != EBPM_RELEASED;
      ctrl_pin_oe_n[`EBPM_CTL_ACK] = 1'b0;
    end
    // Strobes float while the other master owns the bus
    if (useRead) begin
      ctrl_pin_out[`EBPM_CTL_RD]  = busReadStrobe_n;
      ctrl_pin_oe_n[`EBPM_CTL_RD] = busReleased;
    end
    if (useWrUpper) begin
      ctrl_pin_out[`EBPM_CTL_WRU]  = busWriteUpper_n;
      ctrl_pin_oe_n[`EBPM_CTL_WRU] = busReleased;
    end
    if (useWrLower) begin
      ctrl_pin_out[`EBPM_CTL_WRL]  = busWriteLower_n;
      ctrl_pin_oe_n[`EBPM_CTL_WRL] = busReleased;
    end
    // Lower strobe stays off until the first edge after reset
    if (!st.reset2) begin
      ctrl_pin_oe_n[`EBPM_CTL_WRL] = 1'b1;
    end
  end

  // ----------------------------------------
  // Bus controller status
  // ----------------------------------------
  // Low ready stretches the cycle; unused ready pin never stalls
  assign busCycleHold = st.selCtrl[`EBPM_CTL_RDY] && !single && !st.padIn2[`EBPM_CTL_RDY];
  assign busReleased  = st.own == EBPM_RELEASED;
  assign busDataIn    = {st.padIn1[`EBPM_TOP_LSB +: `EBPM_LANE_PINS],
                         st.padIn2[`EBPM_MID_P2_LSB +: `EBPM_LANE_PINS], 16'h0000};
  // Status word: bit 1 cycle held, bit 0 bus released
  assign statusWord   = {30'h0000_0000, busCycleHold, busReleased};

endmodule : ebpm_pin_mux

`default_nettype wire

// *** ebpm_ext_dev.sv ***
`default_nettype none
// ----------------------------------------
// Far side: slow memory and a bus-hungry master
// ----------------------------------------
module ebpm_ext_dev (
  // Clock and bench commands
  input  wire logic       clock,
  input  wire logic [3:0] waitLen,
  input  wire logic       wantBus,
  // Pins seen and driven
  input  wire logic       rdStrobe_n,
  output logic            readyPin,
  output logic            reqPin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt    = 4'h0;
  logic       rdLast = 1'b1;
  logic       reqQ   = 1'b0;
  // Each read start holds ready low waitLen cycles
  always @(posedge clock) begin
    rdLast <= rdStrobe_n;
    reqQ   <= wantBus;
    if (rdLast && !rdStrobe_n) begin
      cnt <= waitLen;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  assign readyPin = (cnt == 4'h0);
  assign reqPin   = reqQ;
endmodule : ebpm_ext_dev
`default_nettype wire

// *** ebpm_pin_mux_chk.sv ***
`default_nettype none
`include "ebpm_regs.svh"
module ebpm_pin_mux_chk (
  // Clock, reset, register bus
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Bus controller side
  input wire logic [31:0] busDataOut,
  input wire logic        busDataDrive,
  input wire logic        busReadStrobe_n,
  input wire logic        busCycleHold,
  input wire logic        busReleased,
  input wire logic        busIdle,
  input wire logic [24:0] busAddr,
  // Pins
  input wire logic [7:0]  data_lane_mid_out,
  input wire logic [7:0]  data_lane_top_out,
  input wire logic [7:0]  data_lane_top_oe_n,
  input wire logic [23:0] addr_bits_out,
  input wire logic [23:0] addr_bits_oe_n,
  input wire logic [5:0]  ctrl_pin_in,
  input wire logic [5:0]  ctrl_pin_out,
  input wire logic [5:0]  ctrl_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Mirror of mode and selects, so checks know each pin's job
  logic [31:0] sMode, sData, sAddr, sCtrl;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sMode <= `EBPM_MODE_RST;
      sData <= `EBPM_SEL_RST;
      sAddr <= `EBPM_SEL_RST;
      sCtrl <= `EBPM_SEL_RST;
    end else if (psel && penable && pwrite) begin
      case (paddr)
        `EBPM_ADDR_MODE:     sMode <= pwdata;
        `EBPM_ADDR_SEL_DATA: sData <= pwdata;
        `EBPM_ADDR_SEL_ADDR: sAddr <= pwdata;
        `EBPM_ADDR_SEL_CTRL: sCtrl <= pwdata;
        default: ;
      endcase
    end
  end
  wire logic busOn = !sMode[1] && !busReleased;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_top_lane: assert property (busOn && busDataDrive && &sData[31:24] |->
    data_lane_top_out == busDataOut[31:24] && data_lane_top_oe_n == 8'h00) else $error("top lane not from bus");
  a_mid_lane: assert property (busOn && busDataDrive && sMode[0] && &sData[23:16] |->
    data_lane_mid_out == busDataOut[23:16]) else $error("mid lane not from bus");
  a_addr_bus: assert property (busOn |-> ((addr_bits_out ^ busAddr[23:0]) & sAddr[23:0]) == 24'h0
    && (addr_bits_oe_n & sAddr[23:0]) == 24'h0) else $error("address pins not from bus");
  a_ready_hold: assert property ((sCtrl[0] && !sMode[1] && !ctrl_pin_in[0]) [*3] |-> busCycleHold)
    else $error("low ready did not hold");
  a_ready_free: assert property (ctrl_pin_in[0] [*3] |-> !busCycleHold) else $error("held with ready high");
  a_ack_level: assert property (!sMode[1] && sCtrl[1] |->
    ctrl_pin_out[1] == !busReleased && !ctrl_pin_oe_n[1]) else $error("ack level wrong");
  a_release_due: assert property ($rose(ctrl_pin_in[2]) && sCtrl[2] && !sMode[1] ##1
    (ctrl_pin_in[2] && busIdle) [*3] |-> busReleased) else $error("release late");
  a_busy_keep: assert property (!busReleased && !busIdle |=> !busReleased) else $error("released while busy");
  a_released_float: assert property (busReleased && !sMode[1] |->
    (~data_lane_top_oe_n & sData[31:24]) == 8'h00 && (~addr_bits_oe_n & sAddr[23:0]) == 24'h0)
    else $error("bus pins driven while released");
  a_read_strobe: assert property (busOn && sCtrl[3] |->
    ctrl_pin_out[3] == busReadStrobe_n && !ctrl_pin_oe_n[3]) else $error("read strobe wrong");
  a_wr_float: assert property ($rose(resetn) |-> ctrl_pin_oe_n[5]) else $error("lower strobe driven in reset");
endmodule : ebpm_pin_mux_chk
bind ebpm_pin_mux ebpm_pin_mux_chk ebpm_pin_mux_chk_i (.*);
`default_nettype wire

// *** tb_top.sv ***
`default_nettype none
`include "ebpm_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, busDataOut = 32'h0, prdata, busDataIn, rdv;
  logic        busDataDrive = 1'b0, busReadStrobe_n = 1'b1, busWriteUpper_n = 1'b1, busWriteLower_n = 1'b1;
  logic        dmaCh0TransferEnd = 1'b0, busIdle = 1'b1, wantBus = 1'b0, readyPin, reqPin;
  logic [24:0] busAddr = 25'h0;
  logic [7:0]  extTop = 8'h00, data_lane_mid_out, data_lane_mid_oe_n, data_lane_top_out, data_lane_top_oe_n;
  logic [23:0] addr_bits_out, addr_bits_oe_n;
  logic [5:0]  ctrl_pin_out, ctrl_pin_oe_n;
  logic        pready, pslverr, busCycleHold, busReleased, addr_top_bit_out, addr_top_bit_oe_n;
  int          bad_count = 0, checked = 0;
  // Floating pins show the far side, a pull-up, or the inverse of the last drive
  wire logic [7:0]  data_lane_mid_in = data_lane_mid_out ^ data_lane_mid_oe_n;
  wire logic [7:0]  data_lane_top_in = (data_lane_top_out & ~data_lane_top_oe_n) | (extTop & data_lane_top_oe_n);
  wire logic [23:0] addr_bits_in = addr_bits_out ^ addr_bits_oe_n;
  wire logic        addr_top_bit_in = addr_top_bit_out ^ addr_top_bit_oe_n;
  wire logic [5:0]  ctrl_pin_in = (ctrl_pin_out & ~ctrl_pin_oe_n)
    | ({1'b1, ~ctrl_pin_out[4:3], reqPin, ~ctrl_pin_out[1], readyPin} & ctrl_pin_oe_n);
  always #5 clock = ~clock;
  ebpm_pin_mux ebpm_pin_mux_i (.*);
  ebpm_ext_dev ebpm_ext_dev_i (.clock(clock), .waitLen(4'h4), .wantBus(wantBus),
    .rdStrobe_n(ctrl_pin_in[3]), .readyPin(readyPin), .reqPin(reqPin));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic guard(input int n);
    if (n >= 8) begin
      bad_count++;
      final_report();
    end
  endtask : guard
  // One APB transfer from a rising edge; an idle edge follows so calls never collide
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 8);
    guard(n);
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_lanes();
    apb(1'b0, 12'h0fc, 32'h0);
    check("unmapped read", rdv, 32'h0);
    busDataDrive <= 1'b1;
    busDataOut <= 32'hc3a5_0000;
    busWriteUpper_n <= 1'b0;
    apb(1'b1, `EBPM_ADDR_PORT_OE2, 32'h0000_ff00);
    apb(1'b1, `EBPM_ADDR_PORT_OUT2, 32'h0000_5a00);
    @(negedge clock);
    check("top lane", {data_lane_top_oe_n, data_lane_top_out}, 16'h00c3);
    check("mid port", {data_lane_mid_oe_n, data_lane_mid_out}, 16'h005a);
    check("strobes 8bit", {ctrl_pin_oe_n[5:4], ctrl_pin_out[4]}, 3'b100);
    @(posedge clock);
    apb(1'b1, `EBPM_ADDR_MODE, 32'h1);
    @(negedge clock);
    check("mid bus", {data_lane_mid_oe_n, data_lane_mid_out}, 16'h00a5);
    check("strobes 16bit", {ctrl_pin_oe_n[5:4], ctrl_pin_out[5:4]}, 4'b0010);
    @(posedge clock);
    apb(1'b1, `EBPM_ADDR_MODE, 32'h3);
    @(negedge clock);
    check("mid single", {data_lane_mid_oe_n, data_lane_mid_out}, 16'h005a);
    check("strobes single", ctrl_pin_oe_n[5:4], 2'b11);
    @(posedge clock);
    busDataDrive <= 1'b0;
    extTop <= 8'h96;
    apb(1'b1, `EBPM_ADDR_MODE, 32'h0);
    @(negedge clock);
    check("top lane in", busDataIn[31:24], 8'h96);
    check("mid lane in", busDataIn[23:16], 8'h5a);
    $display("test lanes done");
  endtask : t_lanes
  task automatic t_addr();
    @(posedge clock);
    busAddr <= 25'h1ab_cdef;
    apb(1'b1, `EBPM_ADDR_SEL_ADDR, 32'hffef_ffd7);
    apb(1'b1, `EBPM_ADDR_PORT_OE, 32'h0010_0008);
    apb(1'b1, `EBPM_ADDR_PORT_OUT, 32'h0010_0000);
    @(negedge clock);
    check("addr oe", addr_bits_oe_n, 24'h00_0020);
    check("addr out", addr_bits_out & 24'hff_ffdf, 24'hbb_cdc7);
    check("addr24 bus", addr_top_bit_out, 1'b1);
    @(posedge clock);
    apb(1'b1, `EBPM_ADDR_MODE, 32'h4);
    @(negedge clock);
    check("addr24 dma", {addr_top_bit_oe_n, addr_top_bit_out}, 2'b00);
    @(posedge clock);
    apb(1'b1, `EBPM_ADDR_SEL_CTRL, 32'h3f);
    apb(1'b1, `EBPM_ADDR_MODE, 32'h0);
    @(negedge clock);
    check("addr24 port", addr_top_bit_oe_n, 1'b1);
    $display("test address done");
  endtask : t_addr
  // Counting window is fixed, wider than the model's wait plus sync delay
  task automatic t_ready();
    int hi;
    hi = 0;
    @(posedge clock);
    busReadStrobe_n <= 1'b0;
    @(negedge clock);
    check("read strobe", {ctrl_pin_oe_n[3], ctrl_pin_out[3]}, 2'b00);
    repeat (12) begin
      @(negedge clock);
      if (busCycleHold === 1'b1) hi++;
    end
    check("hold length", hi, 32'd4);
    @(posedge clock);
    busReadStrobe_n <= 1'b1;
    $display("test ready done");
  endtask : t_ready
  task automatic t_release();
    int n;
    n = 0;
    @(posedge clock);
    busIdle <= 1'b0;
    wantBus <= 1'b1;
    busDataDrive <= 1'b1;
    repeat (8) @(negedge clock);
    check("busy release", busReleased, 1'b0);
    @(posedge clock);
    busIdle <= 1'b1;
    while (ctrl_pin_out[1] !== 1'b0 && n < 8) begin
      @(negedge clock);
      n++;
    end
    guard(n);
    check("released", {busReleased, data_lane_top_oe_n}, 9'h1ff);
    check("released addr", addr_bits_oe_n, 24'hef_fff7);
    @(posedge clock);
    apb(1'b0, `EBPM_ADDR_STATUS, 32'h0);
    check("status released", rdv[0], 1'b1);
    wantBus <= 1'b0;
    n = 0;
    while (ctrl_pin_out[1] !== 1'b1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    guard(n);
    check("owned again", busReleased, 1'b0);
    $display("test release done");
  endtask : t_release
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    @(negedge clock);
    check("lower strobe reset", {ctrl_pin_oe_n[5], ctrl_pin_in[5], ctrl_pin_out[1]}, 3'b111);
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    t_lanes();
    t_addr();
    t_ready();
    t_release();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
